// ==== logic/lis_host.sv ====
// Purpose: Host end: start-up sequencer that initialises the display by instruction.
// Assumes: Reset release marks the supply passing its power-on threshold.
// Notes:   Polling or fixed waits are chosen by poll_busy from the third width instruction on; both end with busy clear.
`timescale 1ns/1ps
`include "lis_params.svh"

module lis_host #(
  parameter int POR_CYC    = `LIS_POR_CYC,
  parameter int FIRST_CYC  = `LIS_FIRST_CYC,
  parameter int SECOND_CYC = `LIS_SECOND_CYC,
  parameter int EXEC_CYC   = `LIS_EXEC_CYC,
  parameter int CLEAR_CYC  = `LIS_CLEAR_CYC
) (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // Instruction port
  lis_bus_if.host    bus,
  // User control
  input  wire logic  start,
  input  wire logic  poll_busy,
  input  wire logic  line_sel,
  input  wire logic  cfg_sel,
  input  wire logic  incr_sel,
  input  wire logic  shift_sel,
  // User status
  output logic       init_done,
  output logic       init_running
);

  // ========================================================================
  // Helpers
  function automatic lis_pkg::lis_byte_type step_code(input logic [2:0] step);
    lis_pkg::lis_byte_type code;
    code = `LIS_CODE_WIDTH;
    case (step)
      3'h3: begin
        code[`LIS_N_BIT] = line_sel;
        code[`LIS_M_BIT] = cfg_sel;
      end
      3'h4: code = `LIS_CODE_OFF;
      3'h5: code = `LIS_CODE_CLEAR;
      3'h6: begin
        code              = `LIS_CODE_ENTRY;
        code[`LIS_ID_BIT] = incr_sel;
        code[`LIS_S_BIT]  = shift_sel;
      end
      default: code = `LIS_CODE_WIDTH;
    endcase
    return code;
  endfunction

  function automatic logic [`LIS_CNT_W-1:0] step_wait(input logic [2:0] step);
    logic [`LIS_CNT_W-1:0] w;
    case (step)
      3'h0:    w = `LIS_CNT_W'(FIRST_CYC);
      3'h1:    w = `LIS_CNT_W'(SECOND_CYC);
      3'h5:    w = `LIS_CNT_W'(CLEAR_CYC);
      default: w = `LIS_CNT_W'(EXEC_CYC);
    endcase
    return w;
  endfunction

  // ========================================================================
  // State
  lis_pkg::lis_host_state_type state_reg, state_next;
  logic [`LIS_CNT_W-1:0]       cnt_reg, cnt_next;
  logic [2:0]                  step_reg, step_next;
  logic                        rs_reg, rs_next;
  logic                        rw_reg, rw_next;
  logic                        stb_reg, stb_next;
  lis_pkg::lis_byte_type       dat_reg, dat_next;
  logic                        oe_reg, oe_next;
  logic                        done_reg, done_next;
  logic                        run_reg, run_next;
  logic                        can_poll;

  // Busy is only trusted once the three width instructions are out.
  assign can_poll = poll_busy && (step_reg >= 3'h2);

  // ========================================================================
  // Next values
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    step_next  = step_reg;
    rs_next    = 1'b0;
    rw_next    = rw_reg;
    stb_next   = 1'b0;
    dat_next   = dat_reg;
    oe_next    = 1'b0;
    done_next  = done_reg;
    run_next   = run_reg;
    if (start) begin
      // A restart treats the display as being in an unknown state.
      state_next = lis_pkg::H_WAIT;
      cnt_next   = `LIS_CNT_W'(POR_CYC);
      step_next  = 3'h0;
      rw_next    = 1'b0;
      done_next  = 1'b0;
      run_next   = 1'b1;
    end else begin
      case (state_reg)
        lis_pkg::H_WAIT: begin
          if (cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1;
          end else if (step_reg > `LIS_LAST_STEP) begin
            state_next = lis_pkg::H_DONE;
            done_next  = 1'b1;
            run_next   = 1'b0;
          end else begin
            state_next = lis_pkg::H_ISSUE;
            stb_next   = 1'b1;
            rw_next    = 1'b0;
            dat_next   = step_code(step_reg);
            oe_next    = 1'b1;
          end
        end
        lis_pkg::H_ISSUE: begin
          if (can_poll) begin
            state_next = lis_pkg::H_RDREQ;
            stb_next   = 1'b1;
            rw_next    = 1'b1;
          end else begin
            state_next = lis_pkg::H_WAIT;
            cnt_next   = step_wait(step_reg);
            step_next  = step_reg + 3'h1;
          end
        end
        lis_pkg::H_RDREQ: begin
          state_next = lis_pkg::H_RDDATA;
        end
        lis_pkg::H_RDDATA: begin
          // Data lines stay released while the device answers.
          if (bus.parallel_data_lines[`LIS_BUSY_BIT]) begin
            state_next = lis_pkg::H_RDREQ;
            stb_next   = 1'b1;
          end else begin
            state_next = lis_pkg::H_WAIT;
            cnt_next   = '0;
            step_next  = step_reg + 3'h1;
            rw_next    = 1'b0;
          end
        end
        lis_pkg::H_DONE: begin
          done_next = 1'b1;
        end
        default: begin
          state_next = lis_pkg::H_WAIT;
          cnt_next   = `LIS_CNT_W'(POR_CYC);
          step_next  = 3'h0;
        end
      endcase
    end
  end

  // ========================================================================
  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= lis_pkg::H_WAIT;
      cnt_reg   <= `LIS_CNT_W'(POR_CYC);
      step_reg  <= 3'h0;
      rs_reg    <= 1'b0;
      rw_reg    <= 1'b0;
      stb_reg   <= 1'b0;
      dat_reg   <= 8'h00;
      oe_reg    <= 1'b0;
      done_reg  <= 1'b0;
      run_reg   <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      step_reg  <= step_next;
      rs_reg    <= rs_next;
      rw_reg    <= rw_next;
      stb_reg   <= stb_next;
      dat_reg   <= dat_next;
      oe_reg    <= oe_next;
      done_reg  <= done_next;
      run_reg   <= run_next;
    end
  end

  assign bus.register_select_line = rs_reg;
  assign bus.read_write           = rw_reg;
  assign bus.bus_strobe           = stb_reg;
  assign bus.host_data_out        = dat_reg;
  assign bus.host_data_oe         = oe_reg;
  assign init_done                = done_reg;
  assign init_running             = run_reg;

endmodule

// ==== logic/lis_params.svh ====
// Purpose: Shared constants for the display start-up sequence blocks.
// Assumes: Clock of 200 MHz; times given in microseconds.
// Notes:   Long counts feed module parameters so that simulation can shorten them.
`ifndef LIS_PARAMS_SVH
`define LIS_PARAMS_SVH

// ==========================================================================
// Timing
`define LIS_CLK_MHZ        200
`define LIS_POR_WAIT_US    2000
`define LIS_FIRST_WAIT_US  2000
`define LIS_SECOND_WAIT_US 40
`define LIS_EXEC_US        40
`define LIS_CLEAR_US       2000
`define LIS_POR_CYC        (`LIS_POR_WAIT_US * `LIS_CLK_MHZ)
`define LIS_FIRST_CYC      (`LIS_FIRST_WAIT_US * `LIS_CLK_MHZ)
`define LIS_SECOND_CYC     (`LIS_SECOND_WAIT_US * `LIS_CLK_MHZ + 1)
`define LIS_EXEC_CYC       (`LIS_EXEC_US * `LIS_CLK_MHZ)
`define LIS_CLEAR_CYC      (`LIS_CLEAR_US * `LIS_CLK_MHZ)

// ==========================================================================
// Instruction codes and field positions
`define LIS_CODE_WIDTH     8'h30
`define LIS_CODE_OFF       8'h08
`define LIS_CODE_CLEAR     8'h01
`define LIS_CODE_ENTRY     8'h04
`define LIS_DL_BIT         4
`define LIS_N_BIT          3
`define LIS_M_BIT          2
`define LIS_DISP_BIT       2
`define LIS_ID_BIT         1
`define LIS_S_BIT          0
`define LIS_BUSY_BIT       7
`define LIS_LAST_STEP      3'h6
`define LIS_CNT_W          22

`endif

// ==== logic/lis_pkg.sv ====
// Purpose: Types shared by both ends of the start-up sequence link.
// Assumes: Nothing beyond the parameter header.
// Notes:   States use Gray codes along the usual path, except the H_WAIT to H_DONE step.
package lis_pkg;

  // ========================================================================
  // Types
  typedef logic [7:0] lis_byte_type;

  typedef enum logic [2:0] {
    H_WAIT   = 3'h0,
    H_ISSUE  = 3'h1,
    H_RDREQ  = 3'h3,
    H_RDDATA = 3'h2,
    H_DONE   = 3'h6
  } lis_host_state_type;

  typedef enum logic [1:0] {
    D_START0 = 2'h0,
    D_START1 = 2'h1,
    D_START2 = 2'h3,
    D_READY  = 2'h2
  } lis_dev_state_type;

endpackage

// ==== logic/lis_bus_if.sv ====
// Purpose: Parallel instruction port between host sequencer and display device.
// Assumes: Both ends run on the same clock.
// Notes:   Undriven data lines read as all ones, like a weak pull-up.
`timescale 1ns/1ps

interface lis_bus_if;

  // ========================================================================
  // Control, driven by the host
  logic                 register_select_line;
  logic                 read_write;
  logic                 bus_strobe;
  lis_pkg::lis_byte_type host_data_out;
  logic                 host_data_oe;
  // Data, driven by the device on reads
  lis_pkg::lis_byte_type dev_data_out;
  logic                 dev_data_oe;
  // Resolved data lines
  lis_pkg::lis_byte_type parallel_data_lines;

  assign parallel_data_lines = host_data_oe ? host_data_out :
                               (dev_data_oe ? dev_data_out : 8'hFF);

  modport host (
    output register_select_line,
    output read_write,
    output bus_strobe,
    output host_data_out,
    output host_data_oe,
    input  parallel_data_lines
  );

  modport device (
    input  register_select_line,
    input  read_write,
    input  bus_strobe,
    output dev_data_out,
    output dev_data_oe,
    input  parallel_data_lines
  );

endinterface

// ==== logic/lis_device.sv ====
// Purpose: Device end: instruction decoder and busy indicator of the display.
// Assumes: Host strobes one cycle per instruction on the shared clock.
// Notes:   Busy reads as set until the third width instruction arrives.
`timescale 1ns/1ps
`include "lis_params.svh"

module lis_device #(
  parameter int EXEC_CYC  = `LIS_EXEC_CYC,
  parameter int CLEAR_CYC = `LIS_CLEAR_CYC
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Instruction port
  lis_bus_if.device   bus,
  // Display state
  output logic        display_on,
  output logic        clear_pulse,
  output logic        line_count_sel,
  output logic        config_sel,
  output logic        addr_increment,
  output logic        shift_on_entry,
  output logic        busy_valid,
  output logic [6:0]  addr_counter
);

  // ========================================================================
  // State
  lis_pkg::lis_dev_state_type  state_reg, state_next;
  logic [`LIS_CNT_W-1:0]       busy_cnt_reg, busy_cnt_next;
  logic                        disp_reg, disp_next;
  logic                        clr_reg, clr_next;
  logic                        n_reg, n_next, m_reg, m_next;
  logic                        id_reg, id_next, s_reg, s_next;
  logic                        valid_reg, valid_next;
  logic [6:0]                  ac_reg, ac_next;
  lis_pkg::lis_byte_type       dout_reg, dout_next;
  logic                        doe_reg, doe_next;
  lis_pkg::lis_byte_type       d;
  logic                        wr_ins, rd_ins, wr_dat, busy_bit;

  assign d        = bus.parallel_data_lines;
  assign wr_ins   = bus.bus_strobe && !bus.register_select_line && !bus.read_write;
  assign rd_ins   = bus.bus_strobe && !bus.register_select_line && bus.read_write;
  assign wr_dat   = bus.bus_strobe && bus.register_select_line && !bus.read_write;
  // Not meaningful before the start-up width instructions finish.
  assign busy_bit = (state_reg != lis_pkg::D_READY) || (busy_cnt_reg != '0);

  // ========================================================================
  // Next values
  always_comb begin
    state_next    = state_reg;
    busy_cnt_next = (busy_cnt_reg != '0) ? busy_cnt_reg - 1'b1 : busy_cnt_reg;
    disp_next     = disp_reg;
    clr_next      = 1'b0;
    n_next        = n_reg;
    m_next        = m_reg;
    id_next       = id_reg;
    s_next        = s_reg;
    valid_next    = (state_reg == lis_pkg::D_READY);
    ac_next       = ac_reg;
    dout_next     = dout_reg;
    doe_next      = 1'b0;
    if (wr_ins) begin
      busy_cnt_next = `LIS_CNT_W'(EXEC_CYC);
      if (d[7:5] == 3'h1) begin
        if (d[`LIS_DL_BIT]) begin
          case (state_reg)
            lis_pkg::D_START0: state_next = lis_pkg::D_START1;
            lis_pkg::D_START1: state_next = lis_pkg::D_START2;
            lis_pkg::D_START2: state_next = lis_pkg::D_READY;
            lis_pkg::D_READY: begin
              n_next = d[`LIS_N_BIT];
              m_next = d[`LIS_M_BIT];
            end
            default: state_next = lis_pkg::D_START0;
          endcase
        end
      end else if (d[7:3] == 5'h01) begin
        disp_next = d[`LIS_DISP_BIT];
      end else if (d == `LIS_CODE_CLEAR) begin
        clr_next      = 1'b1;
        ac_next       = 7'h00;
        id_next       = 1'b1;
        busy_cnt_next = `LIS_CNT_W'(CLEAR_CYC);
      end else if (d[7:2] == 6'h01) begin
        id_next = d[`LIS_ID_BIT];
        s_next  = d[`LIS_S_BIT];
      end
    end else if (rd_ins) begin
      dout_next = {busy_bit, ac_reg};
      doe_next  = 1'b1;
    end else if (wr_dat) begin
      ac_next       = id_reg ? ac_reg + 7'h01 : ac_reg - 7'h01;
      busy_cnt_next = `LIS_CNT_W'(EXEC_CYC);
    end
  end

  // ========================================================================
  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= lis_pkg::D_START0;
      busy_cnt_reg <= '0;
      disp_reg     <= 1'b0;
      clr_reg      <= 1'b0;
      n_reg        <= 1'b0;
      m_reg        <= 1'b0;
      id_reg       <= 1'b1;
      s_reg        <= 1'b0;
      valid_reg    <= 1'b0;
      ac_reg       <= 7'h00;
      dout_reg     <= 8'h00;
      doe_reg      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      busy_cnt_reg <= busy_cnt_next;
      disp_reg     <= disp_next;
      clr_reg      <= clr_next;
      n_reg        <= n_next;
      m_reg        <= m_next;
      id_reg       <= id_next;
      s_reg        <= s_next;
      valid_reg    <= valid_next;
      ac_reg       <= ac_next;
      dout_reg     <= dout_next;
      doe_reg      <= doe_next;
    end
  end

  assign bus.dev_data_out = dout_reg;
  assign bus.dev_data_oe  = doe_reg;
  assign display_on       = disp_reg;
  assign clear_pulse      = clr_reg;
  assign line_count_sel   = n_reg;
  assign config_sel       = m_reg;
  assign addr_increment   = id_reg;
  assign shift_on_entry   = s_reg;
  assign busy_valid       = valid_reg;
  assign addr_counter     = ac_reg;

endmodule

// ==== tb/lis_checker.sv ====
// Purpose: Concurrent checks on the parallel instruction link between both ends.
// Assumes: One clock; rst_n is asynchronous and active low.
// Notes:   The write index wraps after seven writes, so a restart must follow completion.
`timescale 1ns/1ps

module lis_checker #(
  parameter int FIRST_CYC  = 1,
  parameter int SECOND_CYC = 1
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst_n,
  // Link signals
  input wire logic                  register_select_line,
  input wire logic                  read_write,
  input wire logic                  bus_strobe,
  input wire lis_pkg::lis_byte_type host_data_out,
  input wire logic                  host_data_oe,
  input wire lis_pkg::lis_byte_type dev_data_out,
  input wire logic                  dev_data_oe,
  input wire lis_pkg::lis_byte_type parallel_data_lines
);
  // ==========================================================================
  // Helper state
  logic        wr;
  logic [2:0]  idx_reg, idx_next;
  logic [23:0] gap_reg, gap_next;
  logic        seen3_reg, seen3_next;

  assign wr = bus_strobe && !read_write;

  always_comb begin
    idx_next = idx_reg;
    gap_next = (gap_reg != 24'hFF_FFFF) ? gap_reg + 24'h00_0001 : gap_reg;
    seen3_next = seen3_reg || (idx_reg == 3'h3);
    if (wr) begin
      idx_next = (idx_reg == 3'h6) ? 3'h0 : idx_reg + 3'h1;
      gap_next = 24'h00_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_reg <= 3'h0;
      gap_reg <= 24'h00_0000;
      seen3_reg <= 1'b0;
    end else begin
      idx_reg <= idx_next;
      gap_reg <= gap_next;
      seen3_reg <= seen3_next;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Properties
  property p_width_code;
    wr && idx_reg < 3'h3 |-> host_data_out[7:4] == 4'h3 && !register_select_line;
  endproperty
  a_width_code: assert property (p_width_code) else $error("bad width code");
  property p_first_gap;
    wr && idx_reg == 3'h1 |-> gap_reg >= FIRST_CYC;
  endproperty
  a_first_gap: assert property (p_first_gap) else $error("first wait short");
  property p_second_gap;
    wr && idx_reg == 3'h2 |-> gap_reg >= SECOND_CYC;
  endproperty
  a_second_gap: assert property (p_second_gap) else $error("second wait short");
  property p_no_early_read;
    bus_strobe && read_write |-> (seen3_reg || idx_reg == 3'h3) && idx_reg != 3'h1 &&
      idx_reg != 3'h2;
  endproperty
  a_no_early_read: assert property (p_no_early_read) else $error("early poll");
  property p_read_answer;
    bus_strobe && read_write |=> dev_data_oe ##1 !dev_data_oe;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("no poll answer");
  property p_fn_set;
    wr && idx_reg == 3'h3 |-> host_data_out[7:4] == 4'h3 && !host_data_out[0];
  endproperty
  a_fn_set: assert property (p_fn_set) else $error("bad function set");
  property p_off;
    wr && idx_reg == 3'h4 |-> host_data_out == 8'h08;
  endproperty
  a_off: assert property (p_off) else $error("bad display off");
  property p_clear;
    wr && idx_reg == 3'h5 |-> host_data_out == 8'h01;
  endproperty
  a_clear: assert property (p_clear) else $error("bad clear");
  property p_entry;
    wr && idx_reg == 3'h6 |-> host_data_out[7:2] == 6'h01 && !register_select_line;
  endproperty
  a_entry: assert property (p_entry) else $error("bad entry mode");
  property p_read_release;
    bus_strobe && read_write |-> !host_data_oe ##1 !host_data_oe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("host drove on read");
  property p_oe_pulse;
    wr |-> host_data_oe ##1 !host_data_oe;
  endproperty
  a_oe_pulse: assert property (p_oe_pulse) else $error("bad write enable");

endmodule

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench joining host sequencer and device over the link.
// Assumes: Shortened wait parameters on both ends.
// Notes:   Writes are captured at the link and compared with a model queue.
`timescale 1ns/1ps

module tb_top;
  localparam int POR = 20, FST = 30, SND = 9, EXE = 8, CLR = 50;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        start = 1'b0, poll = 1'b0;
  logic        nsel = 1'b0, msel = 1'b0, isel = 1'b0, ssel = 1'b0;
  logic        done, running, disp_on, clr_p, lc, cf, ai, se, bv, last_busy;
  logic [6:0]  ac;
  logic [31:0] seed = 32'h0000_df3a;
  int          mismatches = 0, n_compared = 0, cyc = 0, n_clr = 0, t_rel = 0;
  int          wt[$];
  lis_pkg::lis_byte_type wd[$];

  always #2.5 clk = ~clk;

  lis_bus_if lis_bus_if_i ();
  lis_host #(.POR_CYC(POR), .FIRST_CYC(FST), .SECOND_CYC(SND), .EXEC_CYC(EXE),
    .CLEAR_CYC(CLR)) lis_host_i (.clk(clk), .rst_n(rst_n), .bus(lis_bus_if_i),
    .start(start), .poll_busy(poll), .line_sel(nsel), .cfg_sel(msel), .incr_sel(isel),
    .shift_sel(ssel), .init_done(done), .init_running(running));
  lis_device #(.EXEC_CYC(EXE), .CLEAR_CYC(CLR)) lis_device_i (.clk(clk), .rst_n(rst_n),
    .bus(lis_bus_if_i), .display_on(disp_on), .clear_pulse(clr_p), .line_count_sel(lc),
    .config_sel(cf), .addr_increment(ai), .shift_on_entry(se), .busy_valid(bv),
    .addr_counter(ac));
  lis_checker #(.FIRST_CYC(FST), .SECOND_CYC(SND)) lis_checker_i (.clk(clk), .rst_n(rst_n),
    .register_select_line(lis_bus_if_i.register_select_line),
    .read_write(lis_bus_if_i.read_write), .bus_strobe(lis_bus_if_i.bus_strobe),
    .host_data_out(lis_bus_if_i.host_data_out), .host_data_oe(lis_bus_if_i.host_data_oe),
    .dev_data_out(lis_bus_if_i.dev_data_out), .dev_data_oe(lis_bus_if_i.dev_data_oe),
    .parallel_data_lines(lis_bus_if_i.parallel_data_lines));

  // ==========================================================================
  // Link monitor
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (lis_bus_if_i.bus_strobe && !lis_bus_if_i.read_write) begin
      wd.push_back(lis_bus_if_i.host_data_out);
      wt.push_back(cyc);
    end
    if (lis_bus_if_i.dev_data_oe) begin
      last_busy <= lis_bus_if_i.parallel_data_lines[7];
    end
    if (clr_p) begin
      n_clr <= n_clr + 1;
    end
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic check(input lis_pkg::lis_byte_type seen, input lis_pkg::lis_byte_type exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("TB: compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A count of zero waits for completion; otherwise for that many writes.
  task automatic wait_for(input int n);
    int k;
    k = 0;
    repeat (2) @(negedge clk);
    while (n == 0 ? done !== 1'b1 : wd.size() < n) begin
      @(negedge clk);
      k++;
      if (k > 20000) begin
        mismatches++;
        $display("MISMATCH %0t wait ran out", $time);
        results();
      end
    end
  endtask

  task automatic pulse_rst();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wd.delete();
    wt.delete();
    t_rel = cyc;
  endtask

  // Mode 0 resets, mode 1 restarts by pulse, mode 2 resets again after two writes.
  task automatic run(input int mode, input logic p);
    lis_pkg::lis_byte_type e[$];
    int c0;
    int tdone;
    seed = xs(seed);
    c0 = n_clr;
    @(posedge clk);
    poll <= p;
    {ssel, isel, msel, nsel} <= seed[3:0];
    if (mode != 1) begin
      pulse_rst();
    end else begin
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      wd.delete();
      wt.delete();
    end
    if (mode == 2) begin
      wait_for(2);
      @(posedge clk);
      pulse_rst();
      @(negedge clk);
      check({7'h00, bv}, 8'h00);
      check({6'h00, running, done}, 8'h02);
    end
    wait_for(0);
    tdone = cyc;
    e = '{8'h30, 8'h30, 8'h30, {4'h3, nsel, msel, 2'b00}, 8'h08, 8'h01, {6'h01, isel, ssel}};
    check(8'(wd.size()), 8'h07);
    for (int i = 0; i < 7; i++) begin
      check(wd[i] & (i < 3 ? 8'hF0 : (i == 3 ? 8'hFD : 8'hFF)), e[i]);
    end
    check({7'h00, (wt[1] - wt[0]) >= FST}, 8'h01);
    check({7'h00, (wt[2] - wt[1]) >= SND}, 8'h01);
    for (int i = 2; i < 6; i++) begin
      check({7'h00, (wt[i + 1] - wt[i]) >= (i == 5 ? CLR : EXE)}, 8'h01);
    end
    if (mode != 1) begin
      check({7'h00, (wt[0] - t_rel) >= POR}, 8'h01);
    end
    if (p) begin
      check({7'h00, last_busy}, 8'h00);
    end else begin
      check({7'h00, (tdone - wt[6]) >= EXE}, 8'h01);
    end
    check({5'h00, disp_on, lc, cf}, {6'h00, nsel, msel});
    check({6'h00, ai, se}, {6'h00, isel, ssel});
    check({bv, ac}, 8'h80);
    check(8'(n_clr - c0), 8'h01);
    check({6'h00, running, done}, 8'h01);
    $display("TB: run mode %0d poll %0d ended", mode, p);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    run(0, 1'b0);
    run(1, 1'b1);
    run(2, 1'b1);
    run(1, 1'b0);
    results();
  end

endmodule
